// [fcd_pkg.sv]
// package of command codes, addresses and bus timing for the flash command host
// ----------------------------------------------------------------------------
// Behaviour
// - program and erase start with AA to 555, then 55 to 2AA (byte: AAA, 555)
// - a write needs select and write strobe low with output strobe high
// - F0 written to any address resets the decoder to read mode, except in bypass, after an A0 and while erasing
// - autoselect: unlock pair then 90 to 555; protect state at sector X02/X04
// - in bypass, program is A0 to any address, then data to target
// - bypass left by 90 then 00 to any address
// - sector erase: first five chip-erase writes, then 30 to sector A20-A12
// - erase suspend is one write of B0 to any address
// - erase resume is one write of 30 to any address
// - query entry is 98 to 55 (word) or AA (byte)
// - every command cycle is a write except the designated array read and the protect-state read
// - autoselect holds over any reads until the reset command
// ----------------------------------------------------------------------------
package fcd_pkg;
	localparam int          FCD_AW       = 22;
	localparam int          FCD_DW       = 16;
	localparam logic [21:0] FCD_W_555    = 22'h000555;
	localparam logic [21:0] FCD_W_2AA    = 22'h0002AA;
	localparam logic [21:0] FCD_W_55     = 22'h000055;
	localparam logic [21:0] FCD_B_AAA    = 22'h000AAA;
	localparam logic [21:0] FCD_B_555    = 22'h000555;
	localparam logic [21:0] FCD_B_AA     = 22'h0000AA;
	localparam logic [21:0] FCD_W_PROT   = 22'h000002;
	localparam logic [21:0] FCD_B_PROT   = 22'h000004;
	localparam logic [21:0] FCD_SECT_MSK = 22'h1FF000;
	localparam logic [7:0]  FCD_D_AA     = 8'hAA;
	localparam logic [7:0]  FCD_D_55     = 8'h55;
	localparam logic [7:0]  FCD_D_RESET  = 8'hF0;
	localparam logic [7:0]  FCD_D_AUTO   = 8'h90;
	localparam logic [7:0]  FCD_D_PROG   = 8'hA0;
	localparam logic [7:0]  FCD_D_BYPASS = 8'h20;
	localparam logic [7:0]  FCD_D_ERASE  = 8'h80;
	localparam logic [7:0]  FCD_D_CHIP   = 8'h10;
	localparam logic [7:0]  FCD_D_SECT   = 8'h30;
	localparam logic [7:0]  FCD_D_SUSP   = 8'hB0;
	localparam logic [7:0]  FCD_D_RESUME = 8'h30;
	localparam logic [7:0]  FCD_D_QUERY  = 8'h98;
	localparam logic [7:0]  FCD_D_BYPX   = 8'h00;
	localparam logic [7:0]  FCD_PROT_NO  = 8'h00;
	localparam logic [7:0]  FCD_PROT_YES = 8'h01;
	localparam logic [7:0]  FCD_LOCK_YES = 8'h88;
	localparam logic [7:0]  FCD_LOCK_NO  = 8'h08;
	// strobe phase lengths: 70 ns access, 35 ns write pulse, 20 ns setup/hold
	localparam int          FCD_CLK_NS   = 8;
	localparam int          FCD_ACC_NS   = 70;
	localparam int          FCD_PULSE_NS = 35;
	localparam int          FCD_HOLD_NS  = 20;
	localparam logic [3:0]  FCD_ACC_CYC  = 4'((FCD_ACC_NS + FCD_CLK_NS - 1) / FCD_CLK_NS);
	localparam logic [3:0]  FCD_PUL_CYC  = 4'((FCD_PULSE_NS + FCD_CLK_NS - 1) / FCD_CLK_NS);
	localparam logic [3:0]  FCD_HLD_CYC  = 4'((FCD_HOLD_NS + FCD_CLK_NS - 1) / FCD_CLK_NS);
	// host command codes
	typedef enum logic [3:0] {
		FCD_C_RESET  = 4'h0, FCD_C_AUTO   = 4'h1, FCD_C_PROG   = 4'h2,
		FCD_C_BYPASS = 4'h3, FCD_C_BPROG  = 4'h4, FCD_C_BEXIT  = 4'h5,
		FCD_C_CHIP   = 4'h6, FCD_C_SECT   = 4'h7, FCD_C_SUSP   = 4'h8,
		FCD_C_RESUME = 4'h9, FCD_C_QUERY  = 4'hA, FCD_C_READ   = 4'hB,
		FCD_C_PROT   = 4'hC
	} fcd_cmd_t;
endpackage : fcd_pkg

// [fcd_bus_cycle.sv]
// one strobed bus cycle (write or read) on the flash pins
`timescale 1ns/100ps
module fcd_bus_cycle
	import fcd_pkg::*;
(
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// cycle request
	input  wire logic              start,
	input  wire logic              is_read,
	input  wire logic [FCD_AW-1:0] addr,
	input  wire logic [FCD_DW-1:0] wdata,
	output logic                   done,
	output logic [FCD_DW-1:0]      rdata,
	// flash pins
	output logic [FCD_AW-1:0]      fl_addr,
	output logic                   fl_ce_n,
	output logic                   fl_we_n,
	output logic                   fl_oe_n,
	output logic [FCD_DW-1:0]      fl_dq_o,
	output logic                   fl_dq_oe,
	input  wire logic [FCD_DW-1:0] fl_dq_i
);
	typedef enum logic [1:0] {FCD_B_IDLE = 2'b00, FCD_B_SET = 2'b01,
		FCD_B_PULSE = 2'b11, FCD_B_HOLD = 2'b10} fcd_bstate_t;

	fcd_bstate_t         st_reg, st_next;
	logic [3:0]          cnt_reg, cnt_next;
	logic                rd_reg, rd_next;
	logic [FCD_AW-1:0]   a_reg, a_next;
	logic [FCD_DW-1:0]   d_reg, d_next;
	logic [FCD_DW-1:0]   r_reg, r_next;
	// three-stage sampling of data pins; second and third must agree
	logic [FCD_DW-1:0]   s1_reg, s2_reg, s3_reg;

	always_comb begin
		st_next  = st_reg;
		cnt_next = cnt_reg;
		rd_next  = rd_reg;
		a_next   = a_reg;
		d_next   = d_reg;
		r_next   = r_reg;
		done     = 1'b0;
		unique case (st_reg)
			FCD_B_IDLE: begin
				if (start) begin
					st_next  = FCD_B_SET;
					rd_next  = is_read;
					a_next   = addr;
					d_next   = wdata;
					cnt_next = FCD_HLD_CYC;
				end
			end
			FCD_B_SET: begin
				cnt_next = cnt_reg - 4'h1;
				if (cnt_reg == 4'h1) begin
					st_next  = FCD_B_PULSE;
					cnt_next = rd_reg ? FCD_ACC_CYC + 4'h3 : FCD_PUL_CYC;
				end
			end
			FCD_B_PULSE: begin
				cnt_next = cnt_reg - 4'h1;
				if (cnt_reg == 4'h1) begin
					st_next  = FCD_B_HOLD;
					cnt_next = FCD_HLD_CYC;
					if (rd_reg && s2_reg == s3_reg)
						r_next = s3_reg;
				end
			end
			FCD_B_HOLD: begin
				cnt_next = cnt_reg - 4'h1;
				if (cnt_reg == 4'h1) begin
					st_next = FCD_B_IDLE;
					done    = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_reg  <= FCD_B_IDLE;
			cnt_reg <= 4'h0;
			rd_reg  <= 1'b0;
			a_reg   <= '0;
			d_reg   <= '0;
			r_reg   <= '0;
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
		end else begin
			st_reg  <= st_next;
			cnt_reg <= cnt_next;
			rd_reg  <= rd_next;
			a_reg   <= a_next;
			d_reg   <= d_next;
			r_reg   <= r_next;
			s1_reg  <= fl_dq_i;
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
		end
	end

	// write: ce and we low, oe high; read: ce and oe low, we high
	// ce stays low through a write's hold so it rises after we, never with it
	assign fl_addr  = a_reg;
	assign fl_ce_n  = !(st_reg == FCD_B_PULSE || (st_reg == FCD_B_HOLD && !rd_reg));
	assign fl_we_n  = !(st_reg == FCD_B_PULSE && !rd_reg);
	assign fl_oe_n  = !(st_reg == FCD_B_PULSE && rd_reg);
	assign fl_dq_o  = d_reg;
	assign fl_dq_oe = !rd_reg && st_reg != FCD_B_IDLE;
	assign rdata    = r_reg;

	property p_no_triple_low;
		@(posedge sys_clk) disable iff (!rst_n)
			!(!fl_ce_n && !fl_we_n && !fl_oe_n);
	endproperty
	a_no_triple_low: assert property (p_no_triple_low)
		else $error("all three strobes low");

	property p_write_shape;
		@(posedge sys_clk) disable iff (!rst_n)
			!fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe;
	endproperty
	a_write_shape: assert property (p_write_shape)
		else $error("write strobe without proper select and output strobe");

	property p_we_width;
		@(posedge sys_clk) disable iff (!rst_n)
			$fell(fl_we_n) |-> !fl_we_n [*5];
	endproperty
	a_we_width: assert property (p_we_width)
		else $error("write pulse too short");
endmodule : fcd_bus_cycle

// [fcd_host.sv]
// host controller that issues flash command sequences over the strobe pins
`timescale 1ns/100ps
module fcd_host
	import fcd_pkg::*;
(
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// command port
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	input  wire logic [3:0]        cmd_code,
	input  wire logic [FCD_AW-1:0] cmd_addr,
	input  wire logic [FCD_DW-1:0] cmd_data,
	input  wire logic              byte_mode,
	output logic                   rsp_valid,
	output logic [FCD_DW-1:0]      rsp_data,
	output logic                   rsp_prot,
	output logic                   rsp_lock,
	output logic                   bypass_active,
	// flash pins
	output logic [FCD_AW-1:0]      fl_addr,
	output logic                   fl_ce_n,
	output logic                   fl_we_n,
	output logic                   fl_oe_n,
	output logic [FCD_DW-1:0]      fl_dq_o,
	output logic                   fl_dq_oe,
	input  wire logic [FCD_DW-1:0] fl_dq_i
);
	typedef enum logic [1:0] {FCD_H_IDLE = 2'b00, FCD_H_ISSUE = 2'b01,
		FCD_H_WAIT = 2'b11, FCD_H_RESP = 2'b10} fcd_hstate_t;

	// ------------------------------------------------------------------------
	// address and step decoding
	// ------------------------------------------------------------------------
	function automatic logic [FCD_AW-1:0] unlock_a(input logic second, input logic bm);
		if (second)
			unlock_a = bm ? FCD_B_555 : FCD_W_2AA;
		else
			unlock_a = bm ? FCD_B_AAA : FCD_W_555;
	endfunction : unlock_a

	function automatic logic [FCD_AW-1:0] cmd_a(input logic bm);
		cmd_a = bm ? FCD_B_AAA : FCD_W_555;
	endfunction : cmd_a

	fcd_hstate_t         st_reg, st_next;
	logic [3:0]          code_reg, code_next;
	logic [FCD_AW-1:0]   addr_reg, addr_next;
	logic [FCD_DW-1:0]   data_reg, data_next;
	logic                bm_reg, bm_next;
	logic [2:0]          step_reg, step_next;
	logic                byp_reg, byp_next;
	logic [FCD_DW-1:0]   rsp_reg, rsp_next;

	logic                bc_start;
	logic                bc_read;
	logic                bc_done;
	logic [FCD_AW-1:0]   bc_addr;
	logic [FCD_DW-1:0]   bc_wdata;
	logic [FCD_DW-1:0]   bc_rdata;
	logic [2:0]          n_steps;

	// ------------------------------------------------------------------------
	// per-step address and value of each sequence
	// ------------------------------------------------------------------------
	always_comb begin
		bc_addr  = '0;
		bc_wdata = '0;
		bc_read  = 1'b0;
		n_steps  = 3'd1;
		unique case (code_reg)
			FCD_C_RESET: begin
				bc_wdata = {8'h00, FCD_D_RESET};
			end
			FCD_C_AUTO, FCD_C_BYPASS: begin
				n_steps  = 3'd3;
				bc_addr  = step_reg == 3'd1 ? unlock_a(1'b1, bm_reg) : unlock_a(1'b0, bm_reg);
				bc_wdata = {8'h00, step_reg == 3'd0 ? FCD_D_AA : FCD_D_55};
				if (step_reg == 3'd2)
					bc_wdata = {8'h00, code_reg == FCD_C_AUTO ? FCD_D_AUTO
						: FCD_D_BYPASS};
			end
			FCD_C_PROG: begin
				n_steps  = 3'd4;
				bc_addr  = step_reg == 3'd1 ? unlock_a(1'b1, bm_reg) : unlock_a(1'b0, bm_reg);
				bc_wdata = {8'h00, step_reg == 3'd0 ? FCD_D_AA : FCD_D_55};
				if (step_reg == 3'd2)
					bc_wdata = {8'h00, FCD_D_PROG};
				if (step_reg == 3'd3) begin
					bc_addr  = addr_reg;
					bc_wdata = data_reg;
				end
			end
			FCD_C_BPROG: begin
				n_steps  = 3'd2;
				bc_wdata = {8'h00, FCD_D_PROG};
				if (step_reg == 3'd1) begin
					bc_addr  = addr_reg;
					bc_wdata = data_reg;
				end
			end
			FCD_C_BEXIT: begin
				n_steps  = 3'd2;
				bc_wdata = {8'h00, step_reg == 3'd0 ? FCD_D_AUTO : FCD_D_BYPX};
			end
			FCD_C_CHIP, FCD_C_SECT: begin
				n_steps  = 3'd6;
				bc_addr  = (step_reg == 3'd1 || step_reg == 3'd4)
					? unlock_a(1'b1, bm_reg) : unlock_a(1'b0, bm_reg);
				bc_wdata = {8'h00, (step_reg == 3'd1 || step_reg == 3'd4)
					? FCD_D_55 : FCD_D_AA};
				if (step_reg == 3'd2)
					bc_wdata = {8'h00, FCD_D_ERASE};
				if (step_reg == 3'd5) begin
					if (code_reg == FCD_C_CHIP) begin
						bc_wdata = {8'h00, FCD_D_CHIP};
					end else begin
						bc_addr  = addr_reg & FCD_SECT_MSK;
						bc_wdata = {8'h00, FCD_D_SECT};
					end
				end
			end
			FCD_C_SUSP: bc_wdata = {8'h00, FCD_D_SUSP};
			FCD_C_RESUME: bc_wdata = {8'h00, FCD_D_RESUME};
			FCD_C_QUERY: begin
				bc_addr  = bm_reg ? FCD_B_AA : FCD_W_55;
				bc_wdata = {8'h00, FCD_D_QUERY};
			end
			FCD_C_READ: begin
				bc_read = 1'b1;
				bc_addr = addr_reg;
			end
			FCD_C_PROT: begin
				bc_read = 1'b1;
				bc_addr = (addr_reg & FCD_SECT_MSK) | (bm_reg ? FCD_B_PROT : FCD_W_PROT);
			end
			default: begin
				n_steps = 3'd0;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------------
	always_comb begin
		st_next   = st_reg;
		code_next = code_reg;
		addr_next = addr_reg;
		data_next = data_reg;
		bm_next   = bm_reg;
		step_next = step_reg;
		byp_next  = byp_reg;
		rsp_next  = rsp_reg;
		bc_start  = 1'b0;
		cmd_ready = (st_reg == FCD_H_IDLE);
		unique case (st_reg)
			FCD_H_IDLE: begin
				if (cmd_valid) begin
					st_next   = FCD_H_ISSUE;
					code_next = cmd_code;
					addr_next = cmd_addr;
					data_next = cmd_data;
					bm_next   = byte_mode;
					step_next = 3'd0;
				end
			end
			FCD_H_ISSUE: begin
				if (n_steps == 3'd0) begin
					st_next = FCD_H_RESP;
				end else begin
					bc_start = 1'b1;
					st_next  = FCD_H_WAIT;
				end
			end
			FCD_H_WAIT: begin
				if (bc_done) begin
					if (step_reg == n_steps - 3'd1) begin
						st_next  = FCD_H_RESP;
						rsp_next = bc_read ? bc_rdata : '0;
						// bypass flag set by bypass entry, cleared by bypass exit or by the reset command
						if (code_reg == FCD_C_BYPASS)
							byp_next = 1'b1;
						if (code_reg == FCD_C_BEXIT || code_reg == FCD_C_RESET)
							byp_next = 1'b0;
					end else begin
						step_next = step_reg + 3'd1;
						st_next   = FCD_H_ISSUE;
					end
				end
			end
			FCD_H_RESP: st_next = FCD_H_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_reg   <= FCD_H_IDLE;
			code_reg <= 4'h0;
			addr_reg <= '0;
			data_reg <= '0;
			bm_reg   <= 1'b0;
			step_reg <= 3'd0;
			byp_reg  <= 1'b0;
			rsp_reg  <= '0;
		end else begin
			st_reg   <= st_next;
			code_reg <= code_next;
			addr_reg <= addr_next;
			data_reg <= data_next;
			bm_reg   <= bm_next;
			step_reg <= step_next;
			byp_reg  <= byp_next;
			rsp_reg  <= rsp_next;
		end
	end

	assign rsp_valid     = (st_reg == FCD_H_RESP);
	assign rsp_data      = rsp_reg;
	assign rsp_prot      = rsp_reg[7:0] == FCD_PROT_YES;
	assign rsp_lock      = rsp_reg[7:0] == FCD_LOCK_YES;
	assign bypass_active = byp_reg;

	fcd_bus_cycle u_cycle (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.start    (bc_start),
		.is_read  (bc_read),
		.addr     (bc_addr),
		.wdata    (bc_wdata),
		.done     (bc_done),
		.rdata    (bc_rdata),
		.fl_addr  (fl_addr),
		.fl_ce_n  (fl_ce_n),
		.fl_we_n  (fl_we_n),
		.fl_oe_n  (fl_oe_n),
		.fl_dq_o  (fl_dq_o),
		.fl_dq_oe (fl_dq_oe),
		.fl_dq_i  (fl_dq_i)
	);

	property p_unlock_first;
		@(posedge sys_clk) disable iff (!rst_n)
			(bc_start && step_reg == 3'd0 && (code_reg == FCD_C_PROG
				|| code_reg == FCD_C_CHIP)) |-> bc_wdata[7:0] == FCD_D_AA;
	endproperty
	a_unlock_first: assert property (p_unlock_first)
		else $error("sequence does not open with unlock value");

	property p_unlock_addr;
		@(posedge sys_clk) disable iff (!rst_n)
			(bc_start && step_reg == 3'd0 && code_reg == FCD_C_AUTO)
				|-> bc_addr == (bm_reg ? FCD_B_AAA : FCD_W_555);
	endproperty
	a_unlock_addr: assert property (p_unlock_addr)
		else $error("unlock address ignores bus width");

	property p_sect_last;
		@(posedge sys_clk) disable iff (!rst_n)
			(bc_start && code_reg == FCD_C_SECT && step_reg == 3'd5)
				|-> bc_wdata[7:0] == FCD_D_SECT && (bc_addr & ~FCD_SECT_MSK) == '0;
	endproperty
	a_sect_last: assert property (p_sect_last)
		else $error("sector erase last write wrong");

	property p_resp_one;
		@(posedge sys_clk) disable iff (!rst_n)
			rsp_valid |=> !rsp_valid && cmd_ready;
	endproperty
	a_resp_one: assert property (p_resp_one)
		else $error("response not single cycle");

	property p_bypass_exit;
		@(posedge sys_clk) disable iff (!rst_n)
			(rsp_valid && code_reg == FCD_C_BEXIT) |-> !bypass_active;
	endproperty
	a_bypass_exit: assert property (p_bypass_exit)
		else $error("bypass flag still set after exit");
endmodule : fcd_host

// [fcd_flash_model.sv]
// behavioural flash device answering the host's strobed bus cycles
`timescale 1ns/100ps
module fcd_flash_model
	import fcd_pkg::*;
#(
	parameter int		PWRUP_NS	= 600,
	parameter int		ERASE_NS	= 3000,
	parameter int		PROG_NS		= 80,
	// location of the lock indicator is arbitrary here
	parameter logic [21:0]	LOCK_ADDR	= 22'h000003,
	parameter logic [8:0]	PROT_SECT	= 9'h005
)
(
	// strobes and address
	input	wire logic		ce_n,
	input	wire logic		we_n,
	input	wire logic		oe_n,
	input	wire logic [FCD_AW-1:0]	addr,
	// data bus
	input	wire logic [FCD_DW-1:0]	dq,
	output	logic [FCD_DW-1:0]	dq_o,
	// mode and supply
	input	wire logic		byte_mode,
	input	wire logic		lockout,
	input	wire logic		flock
);
	logic [15:0]	mem [int];
	logic [15:0]	rdv;
	logic [21:0]	a1;
	logic [21:0]	a2;
	logic [7:0]	d;
	int		st;
	int		kq[$];
	time		t_end;
	time		t_prog = 0;

	assign a1 = byte_mode ? 22'h000AAA : 22'h000555;
	assign a2 = byte_mode ? 22'h000555 : 22'h0002AA;
	// an unselected bus shows the inverse, so a stale value never passes as valid
	assign dq_o = (!ce_n && !oe_n) ? rdv : ~rdv;
	// re-evaluated as the output strobe falls, so a fresh program is seen
	always @(addr or st or byte_mode or oe_n or ce_n or flock) begin
		if (st == 7 && addr[11:0] == (byte_mode ? 12'h004 : 12'h002))
			rdv = {15'h0000, addr[20:12] == PROT_SECT};
		else if (st == 7 && addr == LOCK_ADDR)
			rdv = flock ? 16'h0088 : 16'h0008;
		else
			rdv = mem.exists(int'(addr)) ? mem[int'(addr)] : 16'hFFFF;
	end
	always @(posedge lockout)
		st = 0;
	// ------------------------------------------------------------
	// command decoding on the write strobe's rising edge
	// ------------------------------------------------------------
	always @(posedge we_n) begin
		d = dq[7:0];
		if (st == 10 && $time >= t_end)
			st = 0;
		if (lockout)
			st = 0;
		else if ($time < PWRUP_NS || ce_n || !oe_n)
			st = st;
		else if ($time < t_prog)
			st = st;
		else if (st == 10)
			st = (d == 8'hB0) ? 12 : 10;
		else if (st == 12 && d == 8'h30)
			st = 10;
		else if (d == 8'hF0 && st != 3 && st != 8 && st != 9 && st != 13)
			st = 0;
		else
			case (st)
				0: st = (addr == a1 && d == 8'hAA) ? 1 :
					(addr == (byte_mode ? 22'h0000AA : 22'h000055) && d == 8'h98) ? 11 : 0;
				1: st = (addr == a2 && d == 8'h55) ? 2 : 0;
				2: st = addr != a1 ? 0 : d == 8'hA0 ? 3 : d == 8'h90 ? 7 :
					d == 8'h20 ? 8 : d == 8'h80 ? 4 : 0;
				4: st = (addr == a1 && d == 8'hAA) ? 5 : 0;
				5: st = (addr == a2 && d == 8'h55) ? 6 : 0;
				6: begin
					kq.delete();
					if (addr == a1 && d == 8'h10)
						mem.delete();
					else if (d == 8'h30)
						foreach (mem[k])
							if (k[20:12] == addr[20:12])
								kq.push_back(k);
					foreach (kq[i])
						mem.delete(kq[i]);
					t_end = $time + ERASE_NS;
					st = (d == 8'h30 && addr != a1) ? 10 : 0;
				end
				3, 9: begin
					mem[int'(addr)] = dq;
					t_prog = $time + PROG_NS;
					st = (st == 9) ? 8 : 0;
				end
				8: st = d == 8'hA0 ? 9 : d == 8'h90 ? 13 : 8;
				13: st = d == 8'h00 ? 0 : 8;
				default: st = st;
			endcase
	end
endmodule : fcd_flash_model

// [flash_command_decoder_tb.sv]
// self-checking bench of the flash command host against the device model
`timescale 1ns/100ps
module flash_command_decoder_tb;
	import fcd_pkg::*;
	localparam logic [8:0]	PSECT = 9'h005;
	localparam logic [21:0]	LOCK_A = 22'h000003;
	logic			sys_clk, rst_n, cmd_valid, byte_mode, lockout, live, rsp_p;
	logic			flock, in_auto;
	logic [3:0]		cmd_code;
	logic [FCD_AW-1:0]	cmd_addr, fl_addr, a1, a2, ra, sa, sb;
	logic [FCD_DW-1:0]	cmd_data, rsp_data, fl_dq_o, mdl_dq, dq_bus, rsp_d, vd;
	logic			cmd_ready, rsp_valid, rsp_prot, rsp_lock, bypass_active;
	logic			fl_ce_n, fl_we_n, fl_oe_n, fl_dq_oe;
	logic [15:0]		tmem [int];
	logic [37:0]		got[$];
	int			ea[$], ed[$];
	int			fail_count, n_compared, cyc;

	assign dq_bus = fl_dq_oe ? fl_dq_o : mdl_dq;
	fcd_host u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
		.cmd_data(cmd_data), .byte_mode(byte_mode), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_prot(rsp_prot), .rsp_lock(rsp_lock),
		.bypass_active(bypass_active), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n),
		.fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_dq_o(fl_dq_o),
		.fl_dq_oe(fl_dq_oe), .fl_dq_i(dq_bus));
	fcd_flash_model #(.PROT_SECT(PSECT), .LOCK_ADDR(LOCK_A)) u_flash (.ce_n(fl_ce_n),
		.we_n(fl_we_n), .oe_n(fl_oe_n), .addr(fl_addr), .dq(dq_bus), .dq_o(mdl_dq),
		.byte_mode(byte_mode), .lockout(lockout), .flock(flock));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			print_verdict();
		end
	end
	// ------------------------------------------------------------
	// pin monitors
	// ------------------------------------------------------------
	always @(posedge fl_we_n)
		if (fl_ce_n === 1'b0 && fl_oe_n === 1'b1) begin
			got.push_back({fl_addr, fl_dq_o});
			chk(fl_dq_oe, 1'b1);
		end
	always @(negedge sys_clk)
		if (rst_n && fl_ce_n === 1'b0 && fl_oe_n === 1'b0)
			chk({fl_we_n, fl_dq_oe}, 2'b10);
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic put(input int a, input int d);
		ea.push_back(a);
		ed.push_back(d);
	endtask : put
	task automatic ulk();
		put(a1, 8'hAA);
		put(a2, 8'h55);
	endtask : ulk
	task print_verdict;
		$display("compared=%0d mismatches=%0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task automatic run(input logic [3:0] c, input logic [21:0] a, input logic [15:0] d,
		input logic bm);
		int w, f;
		int kq[$];
		ea.delete();
		ed.delete();
		got.delete();
		a1 = bm ? 22'h000AAA : 22'h000555;
		a2 = bm ? 22'h000555 : 22'h0002AA;
		f = bm ? 0 : 32'h00010000;
		case (c)
			FCD_C_RESET:	put(-1, 8'hF0);
			FCD_C_AUTO:	begin ulk(); put(a1, 8'h90); end
			FCD_C_PROG:	begin ulk(); put(a1, 8'hA0); put(a, d | f); end
			FCD_C_BYPASS:	begin ulk(); put(a1, 8'h20); end
			FCD_C_BPROG:	begin put(-1, 8'hA0); put(a, d | f); end
			FCD_C_BEXIT:	begin put(-1, 8'h90); put(-1, 8'h00); end
			FCD_C_CHIP:	begin ulk(); put(a1, 8'h80); ulk(); put(a1, 8'h10); end
			FCD_C_SECT:	begin ulk(); put(a1, 8'h80); ulk(); put(a & 22'h1FF000, 8'h30); end
			FCD_C_SUSP:	put(-1, 8'hB0);
			FCD_C_RESUME:	put(-1, 8'h30);
			FCD_C_QUERY:	put(bm ? 8'hAA : 8'h55, 8'h98);
			default:	;
		endcase
		@(negedge sys_clk);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_addr = a;
		cmd_data = d;
		byte_mode = bm;
		w = 0;
		while (cmd_ready !== 1'b1 && w++ < 500)
			@(negedge sys_clk);
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		w = 0;
		while (rsp_valid !== 1'b1 && w++ < 500) begin
			@(posedge sys_clk);
			#1;
		end
		chk(rsp_valid, 1'b1);
		rsp_d = rsp_data;
		rsp_p = rsp_prot;
		chk(got.size(), ea.size());
		foreach (ea[i])
			if (i < got.size()) begin
				if (ea[i] >= 0)
					chk(got[i][37:16], ea[i]);
				chk(ed[i][16] ? got[i][15:0] : got[i][7:0], ed[i][15:0]);
			end
		if (live && !bm && (c == FCD_C_PROG || c == FCD_C_BPROG))
			tmem[a] = d;
		if (c == FCD_C_CHIP)
			tmem.delete();
		if (c == FCD_C_SECT) begin
			foreach (tmem[k])
				if (k[20:12] == a[20:12])
					kq.push_back(k);
			foreach (kq[i])
				tmem.delete(kq[i]);
		end
		if (c == FCD_C_READ && in_auto) begin
			chk(rsp_d[7:0], flock ? FCD_LOCK_YES : FCD_LOCK_NO);
			chk(rsp_lock, flock);
		end else if (c == FCD_C_READ)
			chk(rsp_d, tmem.exists(a) ? tmem[a] : 16'hFFFF);
		if (c == FCD_C_AUTO)
			in_auto = 1'b1;
		if (c == FCD_C_RESET)
			in_auto = 1'b0;
		if (c == FCD_C_PROT) begin
			chk(rsp_d[7:0], a[20:12] == PSECT ? 8'h01 : 8'h00);
			chk(rsp_p, a[20:12] == PSECT);
		end
	endtask : run
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = 4'h0;
		cmd_addr = 22'h000000;
		cmd_data = 16'h0000;
		byte_mode = 1'b0;
		lockout = 1'b0;
		live = 1'b0;
		flock = 1'b0;
		in_auto = 1'b0;
		void'($urandom(34729));
		repeat (2) @(negedge sys_clk);
		rst_n = 1'b1;
		chk({cmd_ready, bypass_active, fl_we_n, fl_dq_oe}, 4'hA);
		ra = {2'b11, 20'($urandom)};
		run(FCD_C_PROG, ra, 16'h1234, 1'b0);
		repeat (80) @(negedge sys_clk);
		run(FCD_C_READ, ra, 16'h0000, 1'b0);
		live = 1'b1;
		repeat (4) begin
			ra = {2'b11, 20'($urandom)};
			run(FCD_C_PROG, ra, 16'($urandom), 1'b0);
			run(FCD_C_READ, ra, 16'h0000, 1'b0);
		end
		run(FCD_C_PROG, 22'h0002A5, 16'h00C3, 1'b1);
		for (int m = 0; m < 2; m++) begin
			run(FCD_C_AUTO, 22'h000000, 16'h0000, m[0]);
			run(FCD_C_PROT, {1'b0, PSECT, 12'h000}, 16'h0000, m[0]);
			run(FCD_C_PROT, 22'h000000, 16'h0000, m[0]);
			flock = ~m[0];
			run(FCD_C_READ, LOCK_A, 16'h0000, m[0]);
			run(FCD_C_RESET, 22'h3FFFFF, 16'h0000, m[0]);
			run(FCD_C_READ, ra, 16'h0000, 1'b0);
		end
		run(FCD_C_BYPASS, 22'h000000, 16'h0000, 1'b0);
		chk(bypass_active, 1'b1);
		sa = 22'h012005;
		sb = 22'h034007;
		vd = 16'($urandom);
		run(FCD_C_BPROG, sa, vd, 1'b0);
		run(FCD_C_BPROG, sb, ~vd, 1'b0);
		run(FCD_C_BEXIT, 22'h000000, 16'h0000, 1'b0);
		chk(bypass_active, 1'b0);
		run(FCD_C_READ, sa, 16'h0000, 1'b0);
		run(FCD_C_SECT, sa | 22'h000ABC, 16'h0000, 1'b0);
		run(FCD_C_SUSP, 22'h000000, 16'h0000, 1'b0);
		run(FCD_C_READ, sb, 16'h0000, 1'b0);
		run(FCD_C_RESUME, 22'h000000, 16'h0000, 1'b0);
		// wait out the model's erase time before reading the erased sector
		repeat (400) @(negedge sys_clk);
		run(FCD_C_READ, sa, 16'h0000, 1'b0);
		run(FCD_C_READ, sb, 16'h0000, 1'b0);
		run(FCD_C_CHIP, 22'h000000, 16'h0000, 1'b0);
		run(FCD_C_READ, sb, 16'h0000, 1'b0);
		for (int m = 0; m < 2; m++) begin
			run(FCD_C_QUERY, 22'h000000, 16'h0000, m[0]);
			run(FCD_C_RESET, 22'h000000, 16'h0000, m[0]);
		end
		lockout = 1'b1;
		live = 1'b0;
		run(FCD_C_PROG, sb, 16'h5A5A, 1'b0);
		lockout = 1'b0;
		live = 1'b1;
		run(FCD_C_READ, sb, 16'h0000, 1'b0);
		print_verdict();
	end
endmodule : flash_command_decoder_tb
